// File: rtl/uep_controller.sv
// AXI4-Lite front end driving the register link
`timescale 1ns/1ps
module uep_controller (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite slave
  input wire logic [uep_pkg::AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [uep_pkg::AXI_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Register link
  uep_link_if.ctl link
);
  import uep_pkg::*;

  typedef enum logic [4:0] {
    C_IDLE = 5'b00001,
    C_REQ = 5'b00010,
    C_WAIT = 5'b00100,
    C_BRESP = 5'b01000,
    C_RRESP = 5'b10000
  } uep_cstate_t;

  typedef struct packed {
    uep_cstate_t state;
    logic have_aw;
    logic have_w;
    logic is_wr;
    logic err;
    logic [7:0] idx;
    logic [7:0] wd;
    logic [7:0] rd;
  } uep_ctl_state_t;

  uep_ctl_state_t s;
  uep_ctl_state_t next_s;
  logic [7:0] fw;

  assign awready = (s.state == C_IDLE) && !s.have_aw;
  assign wready = (s.state == C_IDLE) && !s.have_w;
  // Write wins: never signal a read taken while a write is offered
  assign arready = (s.state == C_IDLE) && !s.have_aw && !s.have_w && !awvalid && !wvalid;
  assign bvalid = s.state == C_BRESP;
  assign bresp = s.err ? AXI_SLVERR : AXI_OKAY;
  assign rvalid = s.state == C_RRESP;
  assign rresp = s.err ? AXI_SLVERR : AXI_OKAY;
  assign rdata = {24'h0, s.rd};
  assign link.req = s.state == C_REQ;
  assign link.wr = s.is_wr;
  assign link.idx = s.idx;
  assign link.wdata = s.wd;

  // Firmware-side obligations applied to every write
  always_comb begin
    fw = s.wd;
    if (s.idx == IDX_MODE1) begin
      fw = fw & MODE1_WMASK;
      if (fw[3:0] != MODE_ACK_OUT_NAK_IN && fw[3:0] != MODE_ACK_IN) begin
        fw[MODE_STALL_BIT] = 1'b0;
      end
    end
    if ((s.idx == IDX_CNT0 || s.idx == IDX_CNT1) && fw[3:0] > CNT_MAX_IN) begin
      fw[3:0] = CNT_MAX_IN;
    end
  end

  always_comb begin
    next_s = s;
    unique case (s.state)
      C_IDLE: begin
        if (s.have_aw && s.have_w) begin
          next_s.is_wr = 1'b1;
          next_s.wd = fw;
          next_s.state = s.err ? C_BRESP : C_REQ;
        end else begin
          if (awvalid && awready) begin
            next_s.have_aw = 1'b1;
            next_s.idx = awaddr[AXI_IDX_LSB +: 8];
            next_s.err = ~uep_mapped(awaddr[AXI_IDX_LSB +: 8]);
          end
          if (wvalid && wready) begin
            next_s.have_w = 1'b1;
            next_s.wd = wdata[7:0];
            // No low lane means the register is written with zero
            if (!wstrb[0]) begin
              next_s.wd = REG_RESET;
            end
          end
          if (arvalid && arready && !awvalid && !wvalid) begin
            next_s.is_wr = 1'b0;
            next_s.idx = araddr[AXI_IDX_LSB +: 8];
            next_s.err = ~uep_mapped(araddr[AXI_IDX_LSB +: 8]);
            next_s.rd = REG_RESET;
            next_s.state = uep_mapped(araddr[AXI_IDX_LSB +: 8]) ? C_REQ : C_RRESP;
          end
        end
      end
      C_REQ: next_s.state = C_WAIT;
      C_WAIT: begin
        if (link.ack) begin
          next_s.rd = link.rdata;
          next_s.state = s.is_wr ? C_BRESP : C_RRESP;
        end
      end
      C_BRESP: begin
        if (bready) begin
          next_s.have_aw = 1'b0;
          next_s.have_w = 1'b0;
          next_s.state = C_IDLE;
        end
      end
      C_RRESP: begin
        if (rready) begin
          next_s.state = C_IDLE;
        end
      end
      default: next_s.state = C_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '{state: C_IDLE, default: '0};
    end else begin
      s <= next_s;
    end
  end
endmodule

// File: rtl/uep_device.sv
// Endpoint status, count, address and regulator control register logic
`timescale 1ns/1ps
// Functional notes
// - Stall bit stalls ACK-OUT/ACK-IN tokens
// - Firmware keeps stall zero elsewhere
// - Firmware writes zeros to bits six, five
// - ACK-ended transaction sets acked flag
// - Data endpoint modes work like control
// - One count register per endpoint
// - Firmware picks IN data toggle
// - OUT/SETUP load toggle from PID
// - Data-valid cleared on receive errors
// - Endpoint interrupt fires on invalid data
// - Firmware loads IN count 0 to 8
// - Received count is bytes plus two
// - Control count locked until CPU read
// - Regulator off after reset until enabled
// - Suspend disables regulator, optional pull-up
// - Address enable also switches regulator on
// - Pin level readable when regulator off
// - Address register cleared by both resets
// - ACK-OUT mode falls back after OUT
module uep_device (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register link
  uep_link_if.dev link,
  // Token decode from the serial interface engine
  input wire logic tok_valid,
  input wire logic tok_ep,
  input wire uep_pkg::uep_pid_t tok_pid,
  output uep_pkg::uep_hs_t tok_hs,
  output logic tx_toggle,
  output logic [3:0] tx_bytes,
  // Transaction completion from the serial interface engine
  input wire logic tr_valid,
  input wire logic tr_ep,
  input wire uep_pkg::uep_pid_t tr_pid,
  input wire logic tr_ack,
  input wire logic tr_toggle,
  input wire logic tr_err,
  input wire logic [3:0] tr_bytes,
  input wire logic usb_bus_reset,
  output logic [1:0] ep_irq,
  // Device state
  output logic addr_enable,
  output logic [6:0] usb_addr,
  input wire logic suspend,
  // Regulator pin
  input wire logic pullup_supply_pin_i,
  output logic pullup_supply_pin_o,
  output logic pullup_supply_pin_oe,
  output logic pullup_supply_pin_pu
);
  import uep_pkg::*;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] cnt0;
    logic [7:0] mode0;
    logic [7:0] cnt1;
    logic [7:0] mode1;
    logic [1:0] ien;
    logic pullup_supply_pin_en;
    logic lock0;
    logic [2:0] sync;
    logic pin;
    logic [7:0] rdata;
    logic ack;
    logic [1:0] irq;
  } uep_dev_state_t;

  uep_dev_state_t s;
  uep_dev_state_t next_s;
  logic reg_on;
  logic [7:0] rd;
  logic [7:0] c;
  logic [7:0] m;
  logic [7:0] mm;

  assign reg_on = (s.pullup_supply_pin_en | s.addr[ADDR_EN_BIT]) & ~suspend;

  always_comb begin
    pullup_supply_pin_oe = reg_on;
    pullup_supply_pin_o = 1'b1;
    pullup_supply_pin_pu = suspend & s.pullup_supply_pin_en;
  end

  assign addr_enable = s.addr[ADDR_EN_BIT];
  assign usb_addr = s.addr[6:0];
  assign link.rdata = s.rdata;
  assign link.ack = s.ack;
  assign ep_irq = s.irq;
  assign tx_toggle = tok_ep ? s.cnt1[CNT_TOG_BIT] : s.cnt0[CNT_TOG_BIT];
  assign tx_bytes = tok_ep ? s.cnt1[3:0] : s.cnt0[3:0];

  // Handshake decode for the token under way
  always_comb begin
    mm = tok_ep ? s.mode1 : s.mode0;
    tok_hs = UEP_HS_NONE;
    if (tok_valid && mm[3:0] != MODE_DISABLE) begin
      unique case (tok_pid)
        UEP_PID_SETUP: begin
          tok_hs = tok_ep ? UEP_HS_NAK : UEP_HS_ACK;
        end
        UEP_PID_OUT: begin
          tok_hs = UEP_HS_NAK;
          if (mm[3:0] == MODE_ACK_OUT_NAK_IN) begin
            tok_hs = (tok_ep && mm[MODE_STALL_BIT]) ? UEP_HS_STALL : UEP_HS_ACK;
          end
        end
        UEP_PID_IN: begin
          tok_hs = UEP_HS_NAK;
          if (mm[3:0] == MODE_ACK_IN) begin
            tok_hs = (tok_ep && mm[MODE_STALL_BIT]) ? UEP_HS_STALL : UEP_HS_ACK;
          end
        end
        default: begin
          tok_hs = UEP_HS_NONE;
        end
      endcase
    end
  end

  // Read mux
  always_comb begin
    rd = REG_RESET;
    unique case (link.idx)
      IDX_ADDR: rd = s.addr;
      IDX_CNT0: rd = s.cnt0;
      IDX_MODE0: rd = s.mode0;
      IDX_CNT1: rd = s.cnt1;
      IDX_MODE1: rd = s.mode1;
      IDX_IEN: rd = {6'h0, s.ien};
      IDX_USBCTL: rd = REG_RESET | ({7'h0, s.pullup_supply_pin_en} << CTL_PULLUP_SUPPLY_PIN_BIT);
      IDX_PORT2: rd = {7'h0, s.pin & ~reg_on} << P2_PIN_BIT;
      default: rd = REG_RESET;
    endcase
  end

  always_comb begin
    next_s = s;
    c = REG_RESET;
    m = REG_RESET;
    next_s.ack = link.req;
    next_s.irq = 2'h0;
    // Pin level follows once the last two stages agree
    next_s.sync = {s.sync[1:0], pullup_supply_pin_i};
    if (s.sync[1] == s.sync[2]) begin
      next_s.pin = s.sync[2];
    end
    if (link.req && !link.wr) begin
      next_s.rdata = rd;
      if (link.idx == IDX_CNT0) begin
        next_s.lock0 = 1'b0;
      end
    end
    if (link.req && link.wr) begin
      unique case (link.idx)
        IDX_ADDR: next_s.addr = link.wdata;
        IDX_CNT0: begin
          if (!s.lock0) begin
            next_s.cnt0 = link.wdata & CNT_WMASK;
          end
        end
        IDX_MODE0: next_s.mode0 = link.wdata & MODE_LOW_MASK;
        IDX_CNT1: next_s.cnt1 = link.wdata & CNT_WMASK;
        IDX_MODE1: next_s.mode1 = link.wdata & MODE1_WMASK;
        IDX_IEN: next_s.ien = link.wdata[1:0];
        IDX_USBCTL: next_s.pullup_supply_pin_en = link.wdata[CTL_PULLUP_SUPPLY_PIN_BIT];
        default: next_s.ien = s.ien;
      endcase
    end
    // Engine updates come after CPU writes so a same-cycle set wins
    if (tr_valid) begin
      c = tr_ep ? next_s.cnt1 : next_s.cnt0;
      m = tr_ep ? next_s.mode1 : next_s.mode0;
      if (tr_ack) begin
        m[MODE_ACKED_BIT] = 1'b1;
      end
      if (!tr_ep) begin
        m[MODE_SETUP_BIT] = m[MODE_SETUP_BIT] | (tr_pid == UEP_PID_SETUP);
        m[MODE_IN_BIT] = m[MODE_IN_BIT] | (tr_pid == UEP_PID_IN);
        m[MODE_OUT_BIT] = m[MODE_OUT_BIT] | (tr_pid == UEP_PID_OUT);
      end
      if (tr_ack && ((m[3:0] == MODE_ACK_OUT_NAK_IN && tr_pid == UEP_PID_OUT) ||
          (m[3:0] == MODE_ACK_IN && tr_pid == UEP_PID_IN))) begin
        m[3:0] = MODE_NAK_IN_OUT;
      end
      if (tr_pid != UEP_PID_IN) begin
        c[CNT_TOG_BIT] = tr_toggle;
        c[CNT_VALID_BIT] = ~tr_err;
        c[3:0] = tr_bytes + CNT_CRC_BYTES;
        if (!tr_ep) begin
          next_s.lock0 = 1'b1;
        end
      end
      next_s.irq[tr_ep] = next_s.ien[tr_ep];
      if (tr_ep) begin
        next_s.cnt1 = c;
        next_s.mode1 = m;
      end else begin
        next_s.cnt0 = c;
        next_s.mode0 = m;
      end
    end
    if (usb_bus_reset) begin
      next_s.addr = REG_RESET;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

// File: rtl/uep_link_if.sv
// Register access link between controller and endpoint register logic
`timescale 1ns/1ps
interface uep_link_if;
  logic req;
  logic wr;
  logic [7:0] idx;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  modport dev (input req, input wr, input idx, input wdata, output rdata, output ack);
  modport ctl (output req, output wr, output idx, output wdata, input rdata, input ack);
endinterface

// File: rtl/uep_pkg.sv
// Shared constants and types for the endpoint status and count register block
package uep_pkg;
  // Register indices; byte address on AXI is index times four
  localparam logic [7:0] IDX_PORT2 = 8'h02;
  localparam logic [7:0] IDX_ADDR = 8'h10;
  localparam logic [7:0] IDX_CNT0 = 8'h11;
  localparam logic [7:0] IDX_MODE0 = 8'h12;
  localparam logic [7:0] IDX_CNT1 = 8'h13;
  localparam logic [7:0] IDX_MODE1 = 8'h14;
  localparam logic [7:0] IDX_IEN = 8'h1E;
  localparam logic [7:0] IDX_USBCTL = 8'h1F;
  // Field positions and masks
  localparam int ADDR_EN_BIT = 7;
  localparam int CNT_TOG_BIT = 7;
  localparam int CNT_VALID_BIT = 6;
  localparam int MODE_STALL_BIT = 7;
  localparam int MODE_SETUP_BIT = 7;
  localparam int MODE_IN_BIT = 6;
  localparam int MODE_OUT_BIT = 5;
  localparam int MODE_ACKED_BIT = 4;
  localparam int CTL_PULLUP_SUPPLY_PIN_BIT = 6;
  localparam int P2_PIN_BIT = 0;
  localparam logic [7:0] CNT_WMASK = 8'hCF;
  localparam logic [7:0] MODE1_WMASK = 8'h9F;
  localparam logic [7:0] MODE_LOW_MASK = 8'h0F;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [3:0] CNT_CRC_BYTES = 4'h2;
  localparam logic [3:0] CNT_MAX_IN = 4'h8;
  // Mode encodings used by the handshake decode and the acked fallback
  localparam logic [3:0] MODE_DISABLE = 4'h0;
  localparam logic [3:0] MODE_NAK_IN_OUT = 4'h1;
  localparam logic [3:0] MODE_ACK_OUT_NAK_IN = 4'hB;
  localparam logic [3:0] MODE_ACK_IN = 4'hD;
  // AXI4-Lite
  localparam int AXI_ADDR_W = 12;
  localparam int AXI_IDX_LSB = 2;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    UEP_PID_SETUP = 2'h0,
    UEP_PID_OUT = 2'h1,
    UEP_PID_IN = 2'h2
  } uep_pid_t;

  typedef enum logic [1:0] {
    UEP_HS_NONE = 2'h0,
    UEP_HS_ACK = 2'h1,
    UEP_HS_NAK = 2'h2,
    UEP_HS_STALL = 2'h3
  } uep_hs_t;

  function automatic logic uep_mapped(input logic [7:0] idx);
    uep_mapped = (idx == IDX_PORT2) || (idx == IDX_ADDR) || (idx == IDX_CNT0) || (idx == IDX_MODE0) ||
      (idx == IDX_CNT1) || (idx == IDX_MODE1) || (idx == IDX_IEN) || (idx == IDX_USBCTL);
  endfunction
endpackage

// File: tb/test_usb_endpoint_status_count_regs.sv
// Self-checking bench over AXI4-Lite with engine and pin stimulus
`timescale 1ns/1ps
module test_usb_endpoint_status_count_regs;
  import uep_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [AXI_ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb, tx_bytes, tr_bytes;
  logic [1:0] bresp, rresp, ep_irq, ien, r;
  logic tok_valid, tok_ep, tx_toggle, tr_valid, tr_ep, tr_ack, tr_toggle, tr_err, usb_bus_reset, suspend;
  logic addr_enable, ext_pin, pin_o, pin_oe, pin_pu, pin_wire;
  uep_pid_t tok_pid, tr_pid;
  uep_hs_t tok_hs;
  logic [6:0] usb_addr;
  logic [7:0] d;
  int failures = 0, n_checks = 0, cyc = 0;
  logic [7:0] m_tab [7] = '{8'h01, 8'h01, 8'h0B, 8'h0B, 8'h0D, 8'h8B, 8'h8D};
  uep_pid_t p_tab [7] = '{UEP_PID_OUT, UEP_PID_IN, UEP_PID_OUT, UEP_PID_IN, UEP_PID_IN, UEP_PID_OUT, UEP_PID_IN};
  uep_hs_t h_tab [7] = '{UEP_HS_NAK, UEP_HS_NAK, UEP_HS_ACK, UEP_HS_NAK, UEP_HS_ACK, UEP_HS_ACK, UEP_HS_ACK};
  logic [7:0] rst_idx [6] = '{IDX_ADDR, IDX_CNT0, IDX_MODE0, IDX_CNT1, IDX_MODE1, IDX_USBCTL};
  // Wire level: driver, else weak pull-up, else the outside world
  assign pin_wire = pin_oe ? pin_o : (pin_pu ? 1'b1 : ext_pin);
  always #10 aclk = ~aclk;
  uep_link_if uep_link_if_i ();
  uep_controller uep_controller_i (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready), .link(uep_link_if_i));
  uep_device uep_device_i (.aclk(aclk), .aresetn(aresetn), .link(uep_link_if_i), .tok_valid(tok_valid),
    .tok_ep(tok_ep), .tok_pid(tok_pid), .tok_hs(tok_hs), .tx_toggle(tx_toggle), .tx_bytes(tx_bytes),
    .tr_valid(tr_valid), .tr_ep(tr_ep), .tr_pid(tr_pid), .tr_ack(tr_ack), .tr_toggle(tr_toggle), .tr_err(tr_err),
    .tr_bytes(tr_bytes), .usb_bus_reset(usb_bus_reset), .ep_irq(ep_irq), .addr_enable(addr_enable),
    .usb_addr(usb_addr), .suspend(suspend), .pullup_supply_pin_i(pin_wire), .pullup_supply_pin_o(pin_o),
    .pullup_supply_pin_oe(pin_oe), .pullup_supply_pin_pu(pin_pu));
  uep_link_properties uep_link_properties_i (.aclk(aclk), .aresetn(aresetn), .req(uep_link_if_i.req),
    .ack(uep_link_if_i.ack), .tok_valid(tok_valid), .tok_ep(tok_ep), .tok_pid(tok_pid), .tok_hs(tok_hs),
    .tx_toggle(tx_toggle), .tx_bytes(tx_bytes), .tr_valid(tr_valid), .tr_ep(tr_ep), .tr_pid(tr_pid),
    .tr_toggle(tr_toggle), .tr_bytes(tr_bytes), .usb_bus_reset(usb_bus_reset), .ep_irq(ep_irq),
    .addr_enable(addr_enable), .usb_addr(usb_addr), .suspend(suspend), .pullup_supply_pin_oe(pin_oe));

  task automatic close_out();
    if (failures == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  function automatic logic [7:0] cnt_exp(input logic tg, input logic er, input logic [3:0] n);
    return {tg, ~er, 2'b00, n + 4'h2};
  endfunction
  task automatic axw(input logic [7:0] i, input logic [7:0] v);
    @(posedge aclk);
    awaddr <= {2'b00, i, 2'b00};
    wdata <= {24'h00_0000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk({6'h00, bresp}, {6'h00, AXI_OKAY}, "bresp");
  endtask
  task automatic axr(input logic [7:0] i);
    @(posedge aclk);
    araddr <= {2'b00, i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata[7:0];
    r = rresp;
  endtask
  task automatic rc(input logic [7:0] i, input logic [7:0] e);
    axr(i);
    chk(d, e, "reg");
  endtask
  task automatic tok(input logic ep, input uep_pid_t p, input uep_hs_t h);
    @(posedge aclk);
    tok_valid <= 1'b1;
    tok_ep <= ep;
    tok_pid <= p;
    @(negedge aclk);
    chk({6'h00, tok_hs}, {6'h00, h}, "handshake");
    @(posedge aclk);
    tok_valid <= 1'b0;
  endtask
  task automatic tr(input logic ep, input uep_pid_t p, input logic tg, input logic er, input logic [3:0] n);
    @(posedge aclk);
    tr_valid <= 1'b1;
    tr_ep <= ep;
    tok_ep <= ep;
    tr_pid <= p;
    tr_ack <= ~er;
    tr_toggle <= tg;
    tr_err <= er;
    tr_bytes <= n;
    @(posedge aclk);
    tr_valid <= 1'b0;
    @(negedge aclk);
    chk({6'h00, ep_irq}, {6'h00, ien & (2'b01 << ep)}, "irq");
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      close_out();
    end
  end

  initial begin
    int k;
    logic e, tg, er;
    logic [3:0] n;
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, ext_pin, ien} = '0;
    {tok_valid, tok_ep, tr_valid, tr_ep, tr_ack, tr_toggle, tr_err, usb_bus_reset, suspend} = '0;
    {awaddr, araddr, wdata, tr_bytes} = '0;
    wstrb = 4'hF;
    tok_pid = UEP_PID_OUT;
    tr_pid = UEP_PID_OUT;
    void'($urandom(59855));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (k = 0; k < 6; k++) rc(rst_idx[k], REG_RESET);
    @(negedge aclk);
    chk({7'h00, pin_oe}, 8'h00, "oe");
    axr(8'h33);
    chk({6'h00, r}, {6'h00, AXI_SLVERR}, "unmapped");
    axw(IDX_ADDR, 8'hA5);
    rc(IDX_ADDR, 8'hA5);
    chk({7'h00, pin_oe}, 8'h01, "oe");
    @(posedge aclk);
    usb_bus_reset <= 1'b1;
    @(posedge aclk);
    usb_bus_reset <= 1'b0;
    rc(IDX_ADDR, 8'h00);
    axw(IDX_USBCTL, 8'h40);
    chk({7'h00, pin_oe}, 8'h01, "oe");
    @(posedge aclk);
    suspend <= 1'b1;
    @(negedge aclk);
    chk({6'h00, pin_oe, pin_pu}, 8'h01, "suspend");
    @(posedge aclk);
    suspend <= 1'b0;
    axw(IDX_USBCTL, 8'h00);
    for (k = 0; k < 4; k++) begin
      @(posedge aclk);
      ext_pin <= k[0] ^ 1'($urandom);
      repeat (5) @(posedge aclk);
      axr(IDX_PORT2);
      chk({7'h00, d[0]}, {7'h00, ext_pin}, "pin");
    end
    for (k = 0; k < 14; k++) begin
      e = k[0];
      axw(e ? IDX_MODE1 : IDX_MODE0, e ? m_tab[k/2] : m_tab[k/2] & MODE_LOW_MASK);
      tok(e, p_tab[k/2], (e && m_tab[k/2][7]) ? UEP_HS_STALL : h_tab[k/2]);
    end
    axw(IDX_MODE1, 8'hEB);
    rc(IDX_MODE1, 8'h8B);
    axw(IDX_MODE1, 8'h81);
    rc(IDX_MODE1, 8'h01);
    tok(1'b0, UEP_PID_SETUP, UEP_HS_ACK);
    axw(IDX_MODE0, 8'h0B);
    ien = 2'($urandom);
    axw(IDX_IEN, {6'h00, ien});
    for (k = 0; k < 10; k++) begin
      e = 1'($urandom);
      tg = 1'($urandom);
      er = (k == 2) | ($urandom % 4 == 0);
      n = (k == 0) ? 4'h0 : (k == 1) ? 4'h8 : 4'($urandom % 9);
      axw(IDX_MODE1, 8'h0B);
      tr(e, e ? UEP_PID_OUT : uep_pid_t'(2'($urandom % 2)), tg, er, n);
      rc(e ? IDX_CNT1 : IDX_CNT0, cnt_exp(tg, er, n));
      if (e) rc(IDX_MODE1, er ? 8'h0B : 8'h11);
    end
    // Count lock holds off the write until the next read
    tr(1'b0, UEP_PID_OUT, 1'b1, 1'b0, 4'h3);
    axw(IDX_CNT0, 8'h07);
    rc(IDX_CNT0, 8'hC5);
    axw(IDX_CNT0, 8'h07);
    rc(IDX_CNT0, 8'h07);
    axw(IDX_CNT1, 8'hBF);
    rc(IDX_CNT1, 8'h88);
    tok(1'b1, UEP_PID_IN, UEP_HS_NAK);
    chk({3'b000, tx_toggle, tx_bytes}, 8'h18, "tx");
    // Acked IN in ACK-IN mode falls back and leaves the count alone
    axw(IDX_MODE1, 8'h0D);
    tr(1'b1, UEP_PID_IN, 1'b0, 1'b0, 4'h0);
    rc(IDX_MODE1, 8'h11);
    rc(IDX_CNT1, 8'h88);
    // Low byte lane off writes zero
    wstrb <= 4'h0;
    axw(IDX_ADDR, 8'h55);
    wstrb <= 4'hF;
    rc(IDX_ADDR, 8'h00);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rc(IDX_CNT1, REG_RESET);
    tok(1'b0, UEP_PID_SETUP, UEP_HS_NONE);
    close_out();
  end
endmodule

// File: tb/uep_link_properties.sv
// Concurrent checks on the register link and endpoint ports
`timescale 1ns/1ps
module uep_link_properties (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register link
  input wire logic req,
  input wire logic ack,
  // Token and transaction
  input wire logic tok_valid,
  input wire logic tok_ep,
  input wire uep_pkg::uep_pid_t tok_pid,
  input wire uep_pkg::uep_hs_t tok_hs,
  input wire logic tx_toggle,
  input wire logic [3:0] tx_bytes,
  input wire logic tr_valid,
  input wire logic tr_ep,
  input wire uep_pkg::uep_pid_t tr_pid,
  input wire logic tr_toggle,
  input wire logic [3:0] tr_bytes,
  input wire logic usb_bus_reset,
  input wire logic [1:0] ep_irq,
  // Device state and pin
  input wire logic addr_enable,
  input wire logic [6:0] usb_addr,
  input wire logic suspend,
  input wire logic pullup_supply_pin_oe
);
  import uep_pkg::*;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  link_ack_a: assert property (req |=> ack && !req)
    else $error("link ack timing");
  ack_cause_a: assert property (ack |-> $past(req))
    else $error("ack without request");
  stall_scope_a: assert property (tok_valid && tok_hs == UEP_HS_STALL |-> tok_ep && tok_pid != UEP_PID_SETUP)
    else $error("stall outside data endpoint");
  reg_suspend_a: assert property (suspend |-> !pullup_supply_pin_oe)
    else $error("regulator on in suspend");
  reg_addr_a: assert property (addr_enable && !suspend |-> pullup_supply_pin_oe)
    else $error("regulator off with address on");
  bus_reset_a: assert property (usb_bus_reset |=> !addr_enable && usb_addr == 7'h00)
    else $error("address kept over bus reset");
  reset_release_a: assert property ($rose(aresetn) && !suspend |-> !pullup_supply_pin_oe && !addr_enable)
    else $error("regulator on after reset");
  rx_count_a: assert property (tr_valid && tr_pid != UEP_PID_IN ##1 tok_ep == $past(tr_ep)
    |-> tx_bytes == $past(tr_bytes) + 4'h2 && tx_toggle == $past(tr_toggle))
    else $error("received count or toggle wrong");
  irq_cause_a: assert property (ep_irq != 2'b00 |-> $past(tr_valid) && ep_irq == 2'b01 << $past(tr_ep))
    else $error("endpoint irq without transaction");
endmodule
